// ==== hw/itl_defines.svh ====
`ifndef ITL_DEFINES_SVH
`define ITL_DEFINES_SVH

// Current magnitude width, unsigned amperes in fixed point
`define ITL_CUR_W 16
// Time limit width, counted in current-sample update periods
`define ITL_TIME_W 24
// Accumulator value after reset
`define ITL_ACC_RST 1'b0
// Flag values after reset
`define ITL_FLAG_RST 1'b0

`endif

// ==== hw/itl_limiter.sv ====
`timescale 1ns/100ps
`include "itl_defines.svh"
// Functional notes
// (R1) Setpoint is (peak squared minus continuous squared) times time limit.
// (R2) Accumulator updates once per actual-current sample.
// (R3) New total is old total plus current squared minus limit squared.
// (R4) An update that would go below zero holds the total at zero.
// (R5) Reset clears the accumulator to zero.
// (R6) The updated total is compared to the setpoint after every sample.
// (R7) Total strictly above setpoint activates limiting to continuous limit.
// (R8) Limiting with command above continuous limit outputs the limit.
// (R9) Limiting with command at or below limit passes command unchanged.
// (R10) Fault mode raises a fault instead of clamping when over setpoint.
// (R11) Unsigned wide arithmetic; accumulator saturates at its maximum code.
// (R12) Status flag shows total above setpoint, cleared otherwise.
module itl_limiter #(
  parameter int CW = `ITL_CUR_W,     // Current width
  parameter int TW = `ITL_TIME_W     // Time limit width
) (
  input wire logic clk_i,                   // 250 MHz block clock
  input wire logic rstn_i,                  // Async reset, active low
  input wire itl_pkg::itl_cfg_s cfg_i,      // Limits and mode
  input wire itl_pkg::itl_smp_s smp_i,      // Actual current sample
  input wire logic [CW-1:0] cmd_i,          // Commanded current
  output logic [CW-1:0] cur_ref_o,          // Current reference out
  output logic limit_active_o,              // Total above setpoint
  output logic fault_o,                     // Sticky over-energy fault
  output logic [2*CW+TW-1:0] acc_o          // Energy accumulator
);
  import itl_pkg::*;

  localparam int SW = 2 * CW;
  localparam int AW = SW + TW;
  localparam logic [AW-1:0] ACC_MAX = {AW{1'b1}};

  logic sq_vld;
  logic [SW-1:0] act_sq;
  logic [SW-1:0] pk_sq;
  logic [SW-1:0] ct_sq;
  logic [AW-1:0] sp;
  logic [AW-1:0] acc;
  logic [AW-1:0] next_acc;
  logic [SW-1:0] sq_diff;
  logic signed [AW+1:0] sum;

  // Squares of the sampled current and both limits
  itl_sq #(.W(CW)) u_act_sq (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .vld_i(smp_i.valid),
    .a_i(smp_i.cur),
    .vld_o(sq_vld),
    .sq_o(act_sq)
  );
  itl_sq #(.W(CW)) u_pk_sq (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .vld_i(1'b1),
    .a_i(cfg_i.peak_lim),
    .vld_o(),
    .sq_o(pk_sq)
  );
  itl_sq #(.W(CW)) u_ct_sq (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .vld_i(1'b1),
    .a_i(cfg_i.cont_lim),
    .vld_o(),
    .sq_o(ct_sq)
  );

  // Setpoint; a peak below the continuous limit gives a zero setpoint
  assign sq_diff = (pk_sq > ct_sq) ? pk_sq - ct_sq : '0; // [R1]
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sp <= '0;
    end else begin
      sp <= sq_diff * cfg_i.time_lim; // [R1] [R11]
    end
  end

  // One update period is the unit of time, so the step needs no multiply
  always_comb begin
    sum = $signed({2'b00, acc}) + $signed({{(AW-SW+2){1'b0}}, act_sq})
        - $signed({{(AW-SW+2){1'b0}}, ct_sq}); // [R3]
    if (sum < 0) begin
      next_acc = '0; // [R4]
    end else if (sum > $signed({2'b00, ACC_MAX})) begin
      next_acc = ACC_MAX; // [R11]
    end else begin
      next_acc = sum[AW-1:0];
    end
  end

  // Accumulator steps only on a squared sample
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      acc <= {AW{`ITL_ACC_RST}}; // [R5]
    end else if (sq_vld) begin
      acc <= next_acc; // [R2]
    end
  end
  assign acc_o = acc;

  // Compare the freshly updated total in the same edge as the update
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      limit_active_o <= `ITL_FLAG_RST;
    end else if (sq_vld) begin
      limit_active_o <= (next_acc > sp); // [R6] [R7] [R12]
    end
  end

  // Fault latches until reset; the drive must be re-armed deliberately
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fault_o <= `ITL_FLAG_RST;
    end else if (cfg_i.fault_mode && limit_active_o) begin
      fault_o <= 1'b1; // [R10]
    end
  end

  // Output reference; a fault forces zero current
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cur_ref_o <= '0;
    end else if (fault_o) begin
      cur_ref_o <= '0; // [R10]
    end else if (limit_active_o && !cfg_i.fault_mode
                 && cmd_i > cfg_i.cont_lim) begin
      cur_ref_o <= cfg_i.cont_lim; // [R7] [R8]
    end else begin
      cur_ref_o <= cmd_i; // [R9]
    end
  end

  // Checks on the energy path; all but the reset check sleep in reset

  // A peak at or below the continuous limit must leave no headroom
  a_setpoint_zero: assert property ( // [R1]
    @(posedge clk_i) disable iff (!rstn_i)
    (cfg_i.peak_lim <= cfg_i.cont_lim)[*3] |-> sp == '0)
    else $error("setpoint not zero with peak at or below continuous");

  // Between samples the total must not drift
  a_acc_hold: assert property ( // [R2]
    @(posedge clk_i) disable iff (!rstn_i)
    !sq_vld |=> $stable(acc))
    else $error("accumulator moved without a sample");

  // A sample above the continuous limit adds energy unless the total is already at full scale
  a_acc_rise: assert property ( // [R3]
    @(posedge clk_i) disable iff (!rstn_i)
    sq_vld && act_sq > ct_sq && acc != ACC_MAX |=> acc > $past(acc))
    else $error("accumulator did not rise above continuous current");

  // An empty total stays empty on a sample at or below the limit
  a_acc_floor: assert property ( // [R4]
    @(posedge clk_i) disable iff (!rstn_i)
    sq_vld && acc == '0 && act_sq <= ct_sq |=> acc == '0)
    else $error("accumulator left zero on a low sample");

  // Leaving reset, every output must already be clear
  a_reset_clear: assert property ( // [R5]
    @(posedge clk_i) $rose(rstn_i) |->
    acc == '0 && !limit_active_o && !fault_o && cur_ref_o == '0)
    else $error("state not clear when reset was released");

  // The flag judges the total that this very sample produced
  a_cmp_update: assert property ( // [R6]
    @(posedge clk_i) disable iff (!rstn_i)
    sq_vld |=> limit_active_o == (acc > $past(sp)))
    else $error("limit flag disagrees with updated total");

  // Equality with the setpoint is still within budget
  a_limit_strict: assert property ( // [R7]
    @(posedge clk_i) disable iff (!rstn_i)
    sq_vld && next_acc == sp |=> !limit_active_o)
    else $error("limit raised with total equal to setpoint");

  // Limiting caps a large command at the continuous limit
  a_ref_clamp: assert property ( // [R8]
    @(posedge clk_i) disable iff (!rstn_i)
    limit_active_o && !cfg_i.fault_mode && !fault_o
    && cmd_i > cfg_i.cont_lim |=> cur_ref_o == $past(cfg_i.cont_lim))
    else $error("reference not clamped to continuous limit");

  // A small command passes whatever the flag says
  a_ref_pass: assert property ( // [R9]
    @(posedge clk_i) disable iff (!rstn_i)
    !fault_o && cmd_i <= cfg_i.cont_lim |=> cur_ref_o == $past(cmd_i))
    else $error("command not passed through");

  // Over budget in fault mode, the drive must go to zero current
  a_fault_stop: assert property ( // [R10]
    @(posedge clk_i) disable iff (!rstn_i)
    cfg_i.fault_mode && limit_active_o |=> fault_o ##1 cur_ref_o == '0)
    else $error("fault did not stop the output");

  // Once raised, only a reset may clear the fault
  a_fault_sticky: assert property ( // [R10]
    @(posedge clk_i) disable iff (!rstn_i)
    fault_o |=> fault_o)
    else $error("fault cleared without reset");

  // At full scale the total pins instead of wrapping to small values
  a_acc_sat: assert property ( // [R11]
    @(posedge clk_i) disable iff (!rstn_i)
    sq_vld && acc == ACC_MAX && act_sq >= ct_sq |=> acc == ACC_MAX)
    else $error("accumulator wrapped past maximum");

  // The flag moves only with the total it describes
  a_limit_hold: assert property ( // [R12]
    @(posedge clk_i) disable iff (!rstn_i)
    !sq_vld |=> $stable(limit_active_o))
    else $error("limit flag moved without a sample");

  // Main scenarios: limiting on and off, clamping, floor, fault
  c_limit_on: cover property (@(posedge clk_i) disable iff (!rstn_i)
    $rose(limit_active_o));
  c_limit_off: cover property (@(posedge clk_i) disable iff (!rstn_i)
    $fell(limit_active_o));
  c_fault: cover property (@(posedge clk_i) disable iff (!rstn_i)
    $rose(fault_o));
  c_clamp: cover property (@(posedge clk_i) disable iff (!rstn_i)
    limit_active_o && !cfg_i.fault_mode && cmd_i > cfg_i.cont_lim);
  c_floor: cover property (@(posedge clk_i) disable iff (!rstn_i)
    acc != '0 ##1 acc == '0);
endmodule

// ==== hw/itl_pkg.sv ====
package itl_pkg;
  `include "itl_defines.svh"

  // Protection settings, all on the same clock as the block
  typedef struct packed {
    logic [`ITL_CUR_W-1:0] peak_lim;  // Peak current limit
    logic [`ITL_CUR_W-1:0] cont_lim;  // Continuous current limit
    logic [`ITL_TIME_W-1:0] time_lim; // Time limit in update periods
    logic fault_mode;                 // Fault instead of clamping
  } itl_cfg_s;

  // One current sample from the sense path
  typedef struct packed {
    logic valid;                  // One-cycle sample strobe
    logic [`ITL_CUR_W-1:0] cur;   // Actual output current magnitude
  } itl_smp_s;
endpackage

// ==== hw/itl_sq.sv ====
`timescale 1ns/100ps
// Registered squarer; one cycle from operand to square
module itl_sq #(
  parameter int W = 16
) (
  input wire logic clk_i,            // Block clock
  input wire logic rstn_i,           // Async reset, active low
  input wire logic vld_i,            // Operand valid
  input wire logic [W-1:0] a_i,      // Unsigned operand
  output logic vld_o,                // Square valid, one cycle later
  output logic [2*W-1:0] sq_o        // Exact square, cannot overflow
);
  // Square is 2W bits wide, so no product bit is lost
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      vld_o <= 1'b0;
      sq_o <= '0;
    end else begin
      vld_o <= vld_i;
      if (vld_i) begin
        sq_o <= a_i * a_i;
      end
    end
  end
endmodule

// ==== verif/i2t_current_limiter_tb_top.sv ====
`timescale 1ns/100ps
module i2t_current_limiter_tb_top;
  import itl_pkg::*;
  logic clk_i, rstn_i, en, dense, limit_active_o, fault_o;
  logic [15:0] lo, span, cmd, cur_ref_o, e_ref;
  logic [55:0] acc_o;
  itl_cfg_s cfg;
  itl_smp_s smp;
  longint e_acc, p_cur;
  logic p_vld, e_lim, e_flt;
  int err_total, total_checks;

  itl_limiter itl_limiter_inst (.clk_i(clk_i), .rstn_i(rstn_i), .cfg_i(cfg),
    .smp_i(smp), .cmd_i(cmd), .cur_ref_o(cur_ref_o),
    .limit_active_o(limit_active_o), .fault_o(fault_o), .acc_o(acc_o));
  itl_sense_model itl_sense_model_inst (.clk_i(clk_i), .en_i(en),
    .dense_i(dense), .lo_i(lo), .span_i(span), .smp_o(smp), .cmd_o(cmd));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  function automatic longint setp_f(itl_cfg_s c);
    longint d;
    d = longint'(c.peak_lim) * c.peak_lim - longint'(c.cont_lim) * c.cont_lim;
    return (d < 0) ? 0 : d * c.time_lim;
  endfunction

  // Clamp at both ends; the upper end needs far too many samples to reach
  function automatic longint upd_f(longint a, longint c, longint l);
    longint s;
    s = a + c * c - l * l;
    if (s < 0) s = 0;
    if (s > 64'h00FF_FFFF_FFFF_FFFF) s = 64'h00FF_FFFF_FFFF_FFFF;
    return s;
  endfunction

  // Reference: command path first, since it sees the flags of the last edge
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      e_acc = 0;
      p_vld = 0;
      e_lim = 0;
      e_flt = 0;
      e_ref = 16'h0000;
    end else begin
      e_ref = e_flt ? 16'h0000 : (e_lim && !cfg.fault_mode &&
        cmd > cfg.cont_lim) ? cfg.cont_lim : cmd;
      if (cfg.fault_mode && e_lim) e_flt = 1'b1;
      if (p_vld) begin
        e_acc = upd_f(e_acc, p_cur, cfg.cont_lim);
        e_lim = e_acc > setp_f(cfg);
      end
      p_vld = smp.valid;
      p_cur = smp.cur;
    end
  end

  task automatic chk(string n, logic [55:0] exp, logic [55:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %0h seen %0h", n, exp, got);
    end
  endtask

  // Outputs are settled half a cycle after the launching edge
  always @(negedge clk_i) begin
    chk("acc", 56'(e_acc), acc_o);
    chk("limit", 56'(e_lim), 56'(limit_active_o));
    chk("cur_ref", 56'(e_ref), 56'(cur_ref_o));
    chk("fault", 56'(e_flt), 56'(fault_o));
  end

  task automatic do_reset(itl_cfg_s c);
    rstn_i <= 1'b0;
    en <= 1'b0;
    cfg <= c;
    repeat (16) @(negedge clk_i);
    rstn_i <= 1'b1;
    repeat (3) @(negedge clk_i);
  endtask

  task automatic run(logic d, logic [15:0] l, logic [15:0] s, int n);
    en <= 1'b1;
    dense <= d;
    lo <= l;
    span <= s;
    repeat (n) @(negedge clk_i);
    en <= 1'b0;
    repeat (3) @(negedge clk_i);
  endtask

  task automatic close_out;
    if (err_total == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    rstn_i = 1'b0;
    en = 1'b0;
    dense = 1'b0;
    lo = 16'h0001;
    span = 16'h0001;
    cfg = '0;
    err_total = 0;
    total_checks = 0;
    // Setpoint 5 hit exactly by unit steps: equality must not limit
    do_reset('{16'h0001, 16'h0000, 24'h000005, 1'b0});
    run(1'b1, 16'h0001, 16'h0001, 12);
    // Climb past the setpoint, then fall back to the zero floor
    do_reset('{16'h0030, 16'h0020, 24'h000010, 1'b0});
    run(1'b0, 16'h001C, 16'h0010, 400);
    run(1'b1, 16'h0004, 16'h0008, 300);
    // Reset in mid-run, with samples still flowing, clears the total
    run(1'b1, 16'h0028, 16'h0008, 40);
    en <= 1'b1;
    repeat (20) @(negedge clk_i);
    do_reset('{16'h0030, 16'h0020, 24'h000004, 1'b1});
    run(1'b1, 16'h0028, 16'h0008, 100);
    // Peak below continuous leaves a zero setpoint
    do_reset('{16'h0010, 16'h0020, 24'h0000FF, 1'b0});
    run(1'b1, 16'h0021, 16'h0004, 30);
    close_out;
  end
endmodule

// ==== verif/itl_sense_model.sv ====
`timescale 1ns/100ps
// Command source and current sampler in front of the limiter
module itl_sense_model (
  input wire logic clk_i,              // Block clock
  input wire logic en_i,               // Produce traffic
  input wire logic dense_i,            // Sample on every cycle
  input wire logic [15:0] lo_i,        // Lowest current drawn
  input wire logic [15:0] span_i,      // Current spread, at least 1
  output itl_pkg::itl_smp_s smp_o,     // Sample to the limiter
  output logic [15:0] cmd_o            // Command to the limiter
);
  import itl_pkg::*;
  // One process draws all traffic, so the single seed fixes the whole run
  initial begin
    smp_o = '0;
    cmd_o = 16'h0000;
    void'($urandom(31213));
    // Falling edge only, so the limiter never samples a moving value
    forever begin
      @(negedge clk_i);
      smp_o.valid <= en_i && (dense_i || $urandom_range(1, 0) == 1);
      smp_o.cur <= lo_i + 16'($urandom % span_i);
      cmd_o <= en_i ? lo_i + 16'($urandom % (2 * span_i + 1)) : 16'h0000;
    end
  end
endmodule
